// ==== shared/fault_panel_pkg.sv ====
// package: register map, fault bit layout, reset values and timing for the fault panel block
package fault_panel_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FAULT      = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h08;
  localparam logic [7:0] OFS_CTRL       = 8'h0C;
  localparam logic [7:0] OFS_OV_LIMIT   = 8'h10;
  localparam logic [7:0] OFS_UV_LIMIT   = 8'h14;
  localparam logic [7:0] OFS_STATE      = 8'h18;

  // ----------------------------------------------------------------
  // fault bit positions (fault, irq status and irq mask share them)
  // ----------------------------------------------------------------
  localparam int FLT_OVERDRIVE   = 0;
  localparam int FLT_HIGH_REFL   = 1;
  localparam int FLT_OVER_TEMP   = 2;
  localparam int FLT_OVER_CURR   = 3;
  localparam int FLT_UNDER_VOLT  = 4;
  localparam int FLT_OVER_VOLT   = 5;
  localparam int FLT_COMBINER    = 6;
  localparam int FLT_SWITCH_FAIL = 7;
  localparam int FAULT_W         = 8;

  localparam logic [7:0] OP_FAULT_MASK = 8'h0F;
  localparam logic [7:0] HW_FAULT_MASK = 8'hF0;

  // control register fields
  localparam int CTRL_HALF_DUPLEX = 0;

  // state register fields
  localparam int ST_MODE_LSB   = 0;
  localparam int ST_LED_LSB    = 4;
  localparam int ST_SUPPLY_LSB = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OV_LIMIT    = 8'h50;  // 80 V
  localparam logic [7:0] RST_UV_LIMIT    = 8'h2D;  // 45 V
  localparam logic       RST_HALF_DUPLEX = 1'b0;   // full duplex pairs
  localparam logic [7:0] RST_IRQ_MASK    = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 100;
  localparam int FLASH_HALF_MS     = 250;
  localparam int FLASH_HALF_CYCLES = (FLASH_HALF_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_BYPASS  = 2'b00,
    MODE_CHARGE  = 2'b01,
    MODE_OPERATE = 2'b10
  } mode_t;

endpackage

// ==== logic/sync_2ff.sv ====
// two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ==== logic/fault_panel.sv ====
// fault latching, front-panel indicator encoding and remote line control
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fault_panel
  import fault_panel_pkg::*;
#(
  parameter int FLASH_HALF = FLASH_HALF_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // protection sensors (asynchronous pins)
  input  wire logic        overdrive_det,
  input  wire logic        high_refl_det,
  input  wire logic        over_temp_det,
  input  wire logic        over_curr_det,
  input  wire logic        combiner_det,
  input  wire logic        tx_rf_det,
  input  wire logic        to_rx_switching,
  input  wire logic [7:0]  supply_volts,
  input  wire logic        bypass_key,
  // amplifier control and panel
  output logic             amp_bypass,
  output logic             bypass_indicator,
  output logic             reflection_indicator,
  output logic             drive_indicator,
  output logic             break_in_indicator,
  output logic             auto_indicator,
  output logic             irq,
  // remote line: internal serial engine side
  input  wire logic        ser_txd,
  input  wire logic        ser_tx_busy,
  output logic             ser_rxd,
  // remote line: shared/receive pair and transmit pair
  input  wire logic        pair_a_i,
  output logic             pair_a_o,
  output logic             pair_a_oe,
  output logic             pair_b_o,
  output logic             pair_b_oe
);

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [7:0]  volts_s;
  logic [8:0]  det_s;
  logic        od_s, hr_s, ot_s, oc_s, cb_s, rf_s, torx_s, key_s, rxa_s;
  logic        key_d_ff;
  logic        key_press;

  // multi-bit supply value is assumed slowly varying relative to hclk
  sync_2ff #(.WIDTH(17)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({supply_volts, overdrive_det, high_refl_det, over_temp_det,
                over_curr_det, combiner_det, tx_rf_det, to_rx_switching,
                bypass_key, pair_a_i}),
    .sync_out ({volts_s, det_s})
  );
  assign {od_s, hr_s, ot_s, oc_s, cb_s, rf_s, torx_s, key_s, rxa_s} = det_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_d_ff <= 1'b0;
    end else begin
      key_d_ff <= key_s;
    end
  end
  assign key_press = key_s & ~key_d_ff;

  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        addr_phase;
  logic        wr_fault, wr_irq_st, wr_irq_mask, wr_ctrl, wr_ov, wr_uv;
  logic [7:0]  fault_ff, irq_st_ff, irq_mask_ff, ov_limit_ff, uv_limit_ff;
  logic        half_ff;
  mode_t       mode_ff;
  logic [4:0]  led_ff;

  assign addr_phase = hsel & htrans[1] & hready;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_phase & hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  assign wr_fault    = wr_pend_ff & (wr_addr_ff == OFS_FAULT);
  assign wr_irq_st   = wr_pend_ff & (wr_addr_ff == OFS_IRQ_STATUS);
  assign wr_irq_mask = wr_pend_ff & (wr_addr_ff == OFS_IRQ_MASK);
  assign wr_ctrl     = wr_pend_ff & (wr_addr_ff == OFS_CTRL);
  assign wr_ov       = wr_pend_ff & (wr_addr_ff == OFS_OV_LIMIT);
  assign wr_uv       = wr_pend_ff & (wr_addr_ff == OFS_UV_LIMIT);

  // read data is captured in the address phase; unmapped reads as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      case (haddr[7:0])
        OFS_FAULT:      hrdata_ff <= {24'h000000, fault_ff};
        OFS_IRQ_STATUS: hrdata_ff <= {24'h000000, irq_st_ff};
        OFS_IRQ_MASK:   hrdata_ff <= {24'h000000, irq_mask_ff};
        OFS_CTRL:       hrdata_ff <= {31'h00000000, half_ff};
        OFS_OV_LIMIT:   hrdata_ff <= {24'h000000, ov_limit_ff};
        OFS_UV_LIMIT:   hrdata_ff <= {24'h000000, uv_limit_ff};
        OFS_STATE:      hrdata_ff <= {8'h00, volts_s, 7'h00, led_ff, 2'h0, mode_ff};
        default:        hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_ff     <= RST_HALF_DUPLEX;
      ov_limit_ff <= RST_OV_LIMIT;
      uv_limit_ff <= RST_UV_LIMIT;
      irq_mask_ff <= RST_IRQ_MASK;
    end else begin
      if (wr_ctrl)     half_ff     <= hwdata[CTRL_HALF_DUPLEX];
      if (wr_ov)       ov_limit_ff <= hwdata[7:0];
      if (wr_uv)       uv_limit_ff <= hwdata[7:0];
      if (wr_irq_mask) irq_mask_ff <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // fault detection and latching
  // ----------------------------------------------------------------
  logic [7:0] fault_set;
  logic [7:0] fault_clr;
  logic       ov_cond, uv_cond, op_clear, hw_any;

  assign ov_cond = volts_s > ov_limit_ff;
  // under-voltage is only judged once the supply has charged
  assign uv_cond = (volts_s < uv_limit_ff) && (mode_ff == MODE_OPERATE);
  assign hw_any  = |(fault_ff & HW_FAULT_MASK);
  assign op_clear = key_press && (mode_ff == MODE_BYPASS) && !hw_any;

  always_comb begin
    fault_set                  = 8'h00;
    fault_set[FLT_OVERDRIVE]   = od_s;
    fault_set[FLT_HIGH_REFL]   = hr_s;
    fault_set[FLT_OVER_TEMP]   = ot_s;
    fault_set[FLT_OVER_CURR]   = oc_s;
    fault_set[FLT_UNDER_VOLT]  = uv_cond;
    fault_set[FLT_OVER_VOLT]   = ov_cond;
    fault_set[FLT_COMBINER]    = cb_s;
    fault_set[FLT_SWITCH_FAIL] = rf_s & torx_s;
    fault_clr = (wr_fault ? hwdata[7:0] : 8'h00)
              | (op_clear ? OP_FAULT_MASK : 8'h00);
  end

  // a fresh event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_ff <= 8'h00;
    end else begin
      fault_ff <= (fault_ff & ~fault_clr) | fault_set;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status: new latches are events
  // ----------------------------------------------------------------
  logic [7:0] fault_event;
  assign fault_event = fault_set & ~fault_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_ff <= 8'h00;
      irq       <= 1'b0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~(wr_irq_st ? hwdata[7:0] : 8'h00)) | fault_event;
      irq       <= |(irq_st_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= MODE_BYPASS;
    end else begin
      case (mode_ff)
        MODE_BYPASS: begin
          if (op_clear) mode_ff <= MODE_CHARGE;
        end
        MODE_CHARGE: begin
          if (|fault_ff || key_press)          mode_ff <= MODE_BYPASS;
          else if (volts_s >= uv_limit_ff)     mode_ff <= MODE_OPERATE;
        end
        MODE_OPERATE: begin
          if (|fault_ff || key_press) mode_ff <= MODE_BYPASS;
        end
        default: mode_ff <= MODE_BYPASS;
      endcase
    end
  end

  assign amp_bypass = (mode_ff != MODE_OPERATE);

  // ----------------------------------------------------------------
  // common flash timebase
  // ----------------------------------------------------------------
  logic [31:0] flash_cnt_ff;
  logic        flash_ff;

  // one shared phase keeps combined patterns blinking in step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_cnt_ff <= 32'h0000_0000;
      flash_ff     <= 1'b0;
    end else if (flash_cnt_ff == 32'(FLASH_HALF - 1)) begin
      flash_cnt_ff <= 32'h0000_0000;
      flash_ff     <= ~flash_ff;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // indicator encoding: {bypass, reflection, drive, break_in, auto}
  // ----------------------------------------------------------------
  logic [4:0] steady_on, flash_on, nxt_led;

  always_comb begin
    steady_on = 5'h00;
    flash_on  = 5'h00;
    if (fault_ff[FLT_OVERDRIVE]) steady_on = steady_on | 5'h14;
    if (fault_ff[FLT_HIGH_REFL]) steady_on = steady_on | 5'h18;
    if (fault_ff[FLT_OVER_TEMP]) steady_on = steady_on | 5'h1C;
    if (fault_ff[FLT_OVER_CURR]) begin
      steady_on = steady_on | 5'h10;
      flash_on  = flash_on | 5'h02;
    end
    if (fault_ff[FLT_UNDER_VOLT])  flash_on = flash_on | 5'h10;
    if (fault_ff[FLT_OVER_VOLT])   flash_on = flash_on | 5'h11;
    if (fault_ff[FLT_COMBINER])    flash_on = flash_on | 5'h1B;
    if (fault_ff[FLT_SWITCH_FAIL]) flash_on = flash_on | 5'h1F;
    // a manual bypass with nothing latched shows bypass steady
    if (mode_ff == MODE_BYPASS && fault_ff == 8'h00) steady_on = 5'h10;
    if (mode_ff == MODE_CHARGE) flash_on = flash_on | 5'h10;
    // hardware faults take the bypass lamp over to flashing
    if (hw_any) steady_on[4] = 1'b0;
    nxt_led = steady_on | (flash_ff ? flash_on : 5'h00);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_ff <= 5'h10;
    end else begin
      led_ff <= nxt_led;
    end
  end

  assign {bypass_indicator, reflection_indicator, drive_indicator,
          break_in_indicator, auto_indicator} = led_ff;

  // ----------------------------------------------------------------
  // remote line drivers
  // ----------------------------------------------------------------
  // half duplex: one pair, driven only while our frame is going out
  assign pair_a_o  = ser_txd;
  assign pair_a_oe = half_ff & ser_tx_busy;
  assign pair_b_o  = ser_txd;
  assign pair_b_oe = ~half_ff;
  assign ser_rxd   = (half_ff & ser_tx_busy) ? 1'b1 : rxa_s;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_switch_fail_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (rf_s && torx_s) |=> fault_ff[FLT_SWITCH_FAIL] ##1 amp_bypass)
    else $error("switch failure not latched");

  a_hw_key_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (hw_any && key_press && !wr_fault) |=> ($past(fault_ff) & HW_FAULT_MASK) ==
      (fault_ff & $past(fault_ff) & HW_FAULT_MASK) && mode_ff == MODE_BYPASS)
    else $error("hardware fault changed on key press");

  a_op_key_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (op_clear && !od_s && !hr_s && !ot_s && !oc_s) |=>
      (fault_ff & OP_FAULT_MASK) == 8'h00 && mode_ff == MODE_CHARGE)
    else $error("operational faults not cleared by key");

  a_ov_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    ov_cond |=> fault_ff[FLT_OVER_VOLT] ##1 amp_bypass)
    else $error("over-voltage not latched");

  a_uv_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_ff == MODE_OPERATE && volts_s < uv_limit_ff) |=>
      fault_ff[FLT_UNDER_VOLT] ##1 mode_ff == MODE_BYPASS)
    else $error("under-voltage not latched");

  a_hw_bypass_flash: assert property (@(posedge hclk) disable iff (!hresetn)
    hw_any |=> bypass_indicator == $past(flash_ff))
    else $error("bypass not flashing on hardware fault");

  a_op_bypass_steady: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(fault_ff & OP_FAULT_MASK) && !hw_any) |=> bypass_indicator)
    else $error("bypass not steady on operational fault");

  a_overdrive_pattern: assert property (@(posedge hclk) disable iff (!hresetn)
    (fault_ff == 8'h01) |=> drive_indicator && !reflection_indicator)
    else $error("overdrive pattern wrong");

  a_charge_flash: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_ff == MODE_CHARGE && fault_ff == 8'h00) |=> bypass_indicator == $past(flash_ff))
    else $error("bypass not flashing while charging");

  a_flash_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (flash_ff != $past(flash_ff)) |-> $past(flash_cnt_ff) == 32'(FLASH_HALF - 1))
    else $error("flash toggled off its period");

  a_duplex_lines: assert property (@(posedge hclk) disable iff (!hresetn)
    half_ff |-> !pair_b_oe && (pair_a_oe == ser_tx_busy))
    else $error("half duplex line not released");

  a_full_duplex: assert property (@(posedge hclk) disable iff (!hresetn)
    !half_ff |-> pair_b_oe && !pair_a_oe)
    else $error("full duplex pairs wrong");

  a_remote_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_fault && (hwdata[7:0] & fault_set) == 8'h00) |=>
      (fault_ff & $past(hwdata[7:0])) == 8'h00)
    else $error("remote fault clear failed");

endmodule
`default_nettype wire

// ==== verification/panel_partner.sv ====
// operator bypass key and remote controller model for the fault panel
`timescale 1ns/1ps
`default_nettype none
module panel_partner (
  // clock and bench requests
  input  wire logic hclk,
  input  wire logic press,
  input  wire logic ctl_data,
  // device side
  input  wire logic pair_a_oe,
  input  wire logic pair_a_o,
  output logic      bypass_key,
  output logic      pair_a_i
);
  int hold_ff = 0;
  // held several cycles so the synchroniser sees exactly one press
  always @(posedge hclk) begin
    if (press) hold_ff <= 6;
    else if (hold_ff != 0) hold_ff <= hold_ff - 1;
  end
  assign bypass_key = (hold_ff != 0);
  // controller talks only while the device has released the shared pair
  assign pair_a_i = pair_a_oe ? pair_a_o : ctl_data;
endmodule
`default_nettype wire

// ==== verification/test_fault_panel.sv ====
// self-checking testbench for the fault panel block
`timescale 1ns/1ps
`default_nettype none
module test_fault_panel;
  import fault_panel_pkg::*;
  localparam int FH = 4;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, exp_q[$], msk_q[$];
  logic [3:0]  opd;
  logic [7:0]  supply_volts;
  logic        combiner_det, tx_rf_det, to_rx_switching, bypass_key, take, press, ctl;
  logic        amp_bypass, bypass_indicator, reflection_indicator, drive_indicator;
  logic        break_in_indicator, auto_indicator, ser_txd, ser_tx_busy, ser_rxd;
  logic        pair_a_i, pair_a_o, pair_a_oe, pair_b_o, pair_b_oe;
  logic [4:0]  tog;
  logic [8:0]  oe[4] = '{9'h140, 9'h180, 9'h1C0, 9'h100};
  logic [8:0]  om[4] = '{9'h1C0, 9'h1C0, 9'h1C0, 9'h100};
  logic [4:0]  hm[4] = '{5'h10, 5'h11, 5'h1F, 5'h1F};
  logic [4:0]  he[4] = '{5'h10, 5'h11, 5'h1B, 5'h1F};
  int          failures = 0, comparisons = 0;
  assign hready = hreadyout;

  fault_panel #(.FLASH_HALF(FH)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .overdrive_det(opd[0]),
    .high_refl_det(opd[1]), .over_temp_det(opd[2]), .over_curr_det(opd[3]), .combiner_det,
    .tx_rf_det, .to_rx_switching, .supply_volts, .bypass_key, .amp_bypass, .bypass_indicator,
    .reflection_indicator, .drive_indicator, .break_in_indicator, .auto_indicator, .irq,
    .ser_txd, .ser_tx_busy, .ser_rxd, .pair_a_i, .pair_a_o, .pair_a_oe, .pair_b_o, .pair_b_oe);
  panel_partner partner_u (.hclk, .press, .ctl_data(ctl), .pair_a_oe, .pair_a_o, .bypass_key,
    .pair_a_i);

  initial begin
    hclk = 0;
    forever #50 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // read data is judged here, in the data-phase cycle, against the oldest note
  always @(posedge hclk) begin
    if (take && hreadyout) check(hrdata & msk_q.pop_front(), exp_q.pop_front());
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    take <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    take <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic press_key();
    press <= 1'b1;
    cyc(1);
    press <= 1'b0;
    cyc(12);
  endtask
  // lamps seen both lit and dark over two flash periods are flashing
  task automatic watch();
    logic [4:0] on, off, l;
    on = 5'h0;
    off = 5'h0;
    repeat (4 * FH + 2) begin
      @(posedge hclk);
      l = {bypass_indicator, reflection_indicator, drive_indicator, break_in_indicator,
           auto_indicator};
      on |= l;
      off |= ~l;
    end
    tog = on & off;
  endtask
  task automatic final_report();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(100 * 30000);
    failures++;
    final_report();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, take, press, ctl, combiner_det, tx_rf_det, to_rx_switching} = '0;
    {ser_txd, ser_tx_busy, opd, htrans, hsize, haddr, hwdata} = '0;
    supply_volts = 8'h48;
    void'($urandom(58361));
    cyc(12);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    hsize <= 3'h2;
    cyc(2);
    check({pair_b_oe, pair_a_oe, hresp}, 3'b100);
    rd(OFS_CTRL, 32'h0, 32'h1);
    rd(OFS_OV_LIMIT, 32'h50, 32'hFF);
    rd(OFS_UV_LIMIT, 32'h2D, 32'hFF);
    rd(OFS_STATE, 32'h100, 32'h1F3);
    bus(OFS_IRQ_MASK, 1'b1, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      press_key();
      rd(OFS_FAULT, 32'h0, 32'hFF);
      rd(OFS_STATE, 32'h2, 32'h3);
      opd[i] <= 1'b1;
      cyc(8);
      opd[i] <= 1'b0;
      rd(OFS_FAULT, 32'h1 << i, 32'hFF);
      rd(OFS_STATE, {23'h0, oe[i]}, {23'h0, om[i]});
      check({amp_bypass, irq}, 2'b11);
      bus(OFS_IRQ_STATUS, 1'b1, 32'hFF);
      cyc(2);
      check(irq, 1'b0);
    end
    press_key();
    bus(OFS_IRQ_MASK, 1'b1, 32'h0);
    opd <= 4'h9;
    cyc(8);
    opd <= 4'h0;
    watch();
    rd(OFS_STATE, 32'h140, 32'h1C0);
    check({tog[4], tog[1], irq}, 3'b010);
    bus(OFS_IRQ_MASK, 1'b1, 32'hFF);
    supply_volts <= 8'h28;
    press_key();
    rd(OFS_STATE, 32'h1, 32'h3);
    watch();
    check(tog[4], 1'b1);
    supply_volts <= 8'h48;
    cyc(8);
    check({bypass_indicator, amp_bypass}, 2'b00);
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: supply_volts <= 8'h1E;
        1: supply_volts <= 8'(81 + $urandom % 175);
        2: combiner_det <= 1'b1;
        default: {tx_rf_det, to_rx_switching} <= 2'b11;
      endcase
      cyc(8);
      {supply_volts, combiner_det, tx_rf_det, to_rx_switching} <= {8'h48, 3'b000};
      cyc(4);
      watch();
      check(tog & hm[i], he[i]);
      if (i == 2) check(drive_indicator, 1'b0);
      rd(OFS_FAULT, 32'h10 << i, 32'hFF);
      press_key();
      rd(OFS_FAULT, 32'h10 << i, 32'hFF);
      check({amp_bypass, irq}, 2'b11);
      bus(OFS_FAULT, 1'b1, 32'hFF);
      bus(OFS_IRQ_STATUS, 1'b1, 32'hFF);
      rd(OFS_FAULT, 32'h0, 32'hFF);
      press_key();
    end
    bus(OFS_CTRL, 1'b1, 32'h1);
    for (int k = 0; k < 4; k++) begin
      {ser_tx_busy, ser_txd} <= 2'(k);
      ctl <= 1'($urandom);
      cyc(4);
      check({pair_b_oe, pair_a_oe}, {1'b0, ser_tx_busy});
      check(ser_rxd, ser_tx_busy ? 1'b1 : ctl);
      if (ser_tx_busy) check(pair_a_o, ser_txd);
    end
    bus(OFS_CTRL, 1'b1, 32'h0);
    ser_txd <= 1'($urandom);
    ctl <= 1'($urandom);
    cyc(4);
    check({pair_b_oe, pair_a_oe, pair_b_o, ser_rxd}, {2'b10, ser_txd, ctl});
    final_report();
  end
endmodule
`default_nettype wire
